// [bench/shl_link_monitor.sv]
`timescale 1ns/1ns
module shl_link_monitor
    import shl_pkg::*;
(
    // Clock and reset
    input wire logic       SYS_CLK,
    input wire logic       RSTN,
    // Received frame
    input wire logic       RX_VALID,
    input wire logic [7:0] RX_CTRL,
    // Frame to send
    input wire logic       TX_VALID,
    input wire logic [7:0] TX_CTRL,
    input wire logic [1:0] TX_PLEN,
    input wire logic [7:0] TX_PAY0,
    input wire logic [7:0] TX_PAY1,
    // Link state
    input wire logic       I_SENT,
    input wire logic       LINK_UP,
    input wire logic       LINK_RESET,
    input wire logic       FLUSH,
    input wire logic [7:0] WIN,
    input wire logic       SREJ_EN,
    input wire logic [2:0] NS,
    input wire logic [2:0] NR,
    input wire logic [2:0] DNR
);
    localparam logic [7:0] RS = {CTL_U_PFX, MOD_RESET};
    localparam logic [7:0] UA = {CTL_U_PFX, MOD_UACK};
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    property p_ua_bare;
        TX_VALID && TX_CTRL == UA |-> TX_PLEN == 2'h0; endproperty
    a_ua_bare: assert property (p_ua_bare) else $error("ua payload");
    property p_win_byte; TX_VALID && TX_CTRL == RS && TX_PLEN != 2'h0
        |-> TX_PAY0 inside {[WIN_MIN:WIN_DEF]}; endproperty
    a_win_byte: assert property (p_win_byte) else $error("bad window");
    property p_cap_rfu; TX_VALID && TX_CTRL == RS && TX_PLEN == 2'h2
        |-> TX_PAY1[7:1] == 7'h00; endproperty
    a_cap_rfu: assert property (p_cap_rfu) else $error("reserved caps");
    property p_win_fix;
        $changed(WIN) |-> $past(RX_VALID); endproperty
    a_win_fix: assert property (p_win_fix) else $error("window moved");
    property p_srej;
        $rose(SREJ_EN) |-> $past(RX_VALID); endproperty
    a_srej: assert property (p_srej) else $error("srej unasked");
    property p_zero;
        $rose(LINK_UP) |-> NS == 3'h0 && NR == 3'h0 && DNR == 3'h0; endproperty
    a_zero: assert property (p_zero) else $error("sequence not zero");
    property p_ns;
        LINK_UP && I_SENT && !RX_VALID |=> NS == $past(NS) + 3'h1; endproperty
    a_ns: assert property (p_ns) else $error("send count");
    property p_drop; !LINK_UP && !TX_VALID && RX_VALID
        && RX_CTRL[7:5] != CTL_U_PFX |=> !TX_VALID && !LINK_UP; endproperty
    a_drop: assert property (p_drop) else $error("frame not dropped");
    property p_flush; $rose(TX_VALID) && TX_CTRL == RS
        |-> FLUSH && LINK_RESET; endproperty
    a_flush: assert property (p_flush) else $error("no flush");
endmodule

bind shl_link shl_link_monitor i_mon (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .RX_VALID(RX_VALID), .RX_CTRL(RX_CTRL),
    .TX_VALID(TX_VALID), .TX_CTRL(TX_CTRL), .TX_PLEN(TX_PLEN),
    .TX_PAY0(TX_PAY0), .TX_PAY1(TX_PAY1), .I_SENT(I_SENT),
    .LINK_UP(LINK_UP), .LINK_RESET(LINK_RESET), .FLUSH(FLUSH),
    .WIN(WIN), .SREJ_EN(SREJ_EN), .NS(NS), .NR(NR),
    .DNR(DNR)
);

// [bench/shl_peer.sv]
`timescale 1ns/1ns
module shl_peer (
    // Clock and pace
    input  wire logic       clk,
    input  wire logic       slow,
    // Toward the block
    output logic            rx_valid,
    output logic            rx_sof,
    output logic      [7:0] rx_ctrl,
    output logic      [1:0] rx_plen,
    output logic      [7:0] rx_pay0,
    output logic      [7:0] rx_pay1,
    // From the block
    output logic            tx_ready
);
    logic       ph = 1'b0;
    logic [7:0] c = 8'h00;
    logic [7:0] p0 = 8'h00;
    logic [7:0] p1 = 8'h00;
    logic [1:0] n = 2'h0;
    initial rx_valid = 1'b0;
    initial rx_sof = 1'b0;
    always @(posedge clk) ph <= ~ph;
    // Idle lines toggle so stale bytes never pass for a frame
    assign rx_ctrl = rx_valid ? c : c ^ {8{ph}};
    assign rx_plen = rx_valid ? n : n ^ {2{ph}};
    assign rx_pay0 = rx_valid ? p0 : p0 ^ {8{ph}};
    assign rx_pay1 = rx_valid ? p1 : p1 ^ {8{ph}};
    // Slow peer takes a frame only every other cycle
    assign tx_ready = !slow || ph;
    task automatic send(input logic [7:0] ctl, input logic [1:0] len,
                        input logic [7:0] w, input logic [7:0] cap);
        @(posedge clk);
        rx_sof <= 1'b1;
        @(posedge clk);
        rx_sof <= 1'b0;
        rx_valid <= 1'b1;
        c <= ctl;
        n <= len;
        p0 <= w;
        p1 <= cap;
        @(posedge clk);
        rx_valid <= 1'b0;
    endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
    import shl_pkg::*;
    localparam logic [7:0] RS = {CTL_U_PFX, MOD_RESET};
    localparam logic [7:0] UA = {CTL_U_PFX, MOD_UACK};
    logic        SYS_CLK = 1'b0;
    logic        RSTN = 1'b0;
    logic        HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0]  HTRANS = 2'h0;
    logic        HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic        I_SENT = 1'b0;
    logic        I_RCVD_OK = 1'b0;
    logic        ACK_SENT = 1'b0;
    logic [2:0]  ACK_NR = 3'h0;
    logic        slow = 1'b0;
    logic        rd_ph = 1'b0;
    logic [15:0] rnd = 16'd67;
    logic [31:0] HRDATA;
    logic        HREADYOUT, HRESP, TX_VALID, TX_READY, RX_VALID, RX_SOF;
    logic [7:0]  RX_CTRL, RX_PAY0, RX_PAY1, TX_CTRL, TX_PAY0, TX_PAY1, WIN;
    logic [1:0]  RX_PLEN, TX_PLEN;
    logic        LINK_UP, LINK_RESET, FLUSH, SREJ_EN, ACK_DUE, RETX_DUE;
    logic [2:0]  NS, NR, DNR;
    logic [23:0] exp_tx[$];
    logic [63:0] exp_rd[$];
    int          num_errors = 0;
    int          cmp_count = 0;

    always #50 SYS_CLK = ~SYS_CLK;

    shl_link i_dut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_VALID(RX_VALID),
        .RX_CTRL(RX_CTRL), .RX_PLEN(RX_PLEN), .RX_PAY0(RX_PAY0),
        .RX_PAY1(RX_PAY1), .RX_SOF(RX_SOF), .TX_VALID(TX_VALID),
        .TX_READY(TX_READY), .TX_CTRL(TX_CTRL), .TX_PLEN(TX_PLEN),
        .TX_PAY0(TX_PAY0), .TX_PAY1(TX_PAY1), .I_SENT(I_SENT),
        .I_RCVD_OK(I_RCVD_OK), .ACK_NR(ACK_NR), .ACK_SENT(ACK_SENT),
        .LINK_UP(LINK_UP), .LINK_RESET(LINK_RESET), .FLUSH(FLUSH),
        .WIN(WIN), .SREJ_EN(SREJ_EN), .NS(NS), .NR(NR), .DNR(DNR),
        .ACK_DUE(ACK_DUE), .RETX_DUE(RETX_DUE));

    shl_peer i_peer (.clk(SYS_CLK), .slow(slow), .rx_valid(RX_VALID),
        .rx_sof(RX_SOF), .rx_ctrl(RX_CTRL), .rx_plen(RX_PLEN),
        .rx_pay0(RX_PAY0), .rx_pay1(RX_PAY1), .tx_ready(TX_READY));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return (s >> 1) ^ (s[0] ? 16'hb400 : 16'h0000);
    endfunction
    function automatic logic inwin(input logic [2:0] x, y, z);
        return (x <= z) ? (x <= y && y < z) : (y >= x || y < z);
    endfunction

    task automatic summarize;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp_frame(input logic [23:0] e, input logic [23:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("BAD tx_frame exp %h got %h", e, g);
        end
    endtask
    task automatic cmp_word(input logic [63:0] e, input logic [31:0] g);
        cmp_count++;
        if ((g & e[63:32]) !== e[31:0]) begin
            num_errors++;
            $display("BAD hrdata exp %h got %h", e[31:0], g & e[63:32]);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge SYS_CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        @(posedge SYS_CLK);
        while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge SYS_CLK);
        while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        exp_rd.push_back({m, e});
        ahb(1'b0, a, 32'h0);
    endtask
    task automatic drain(input int n);
        repeat (n) if (exp_tx.size() != 0) @(posedge SYS_CLK);
        repeat (20) @(posedge SYS_CLK);
        if (exp_tx.size() != 0) begin
            num_errors++;
            $display("BAD tx_left exp 0 got %0d", exp_tx.size());
            exp_tx.delete();
        end
    endtask

    // Scoreboard side: frames taken by the peer and read data phases
    always @(posedge SYS_CLK) begin
        if (RSTN && TX_VALID === 1'b1 && TX_READY)
            cmp_frame(exp_tx.size() != 0 ? exp_tx.pop_front() : 24'h0,
                {TX_CTRL, TX_PLEN == 2'h0 ? WIN_DEF : TX_PAY0,
                 TX_PLEN < 2'h2 ? CAP_DEF : TX_PAY1});
        if (rd_ph && HREADYOUT)
            cmp_word(exp_rd.pop_front(), HRDATA);
        if (HREADYOUT)
            rd_ph <= HSEL && HTRANS[1] && !HWRITE;
    end

    initial begin
        repeat (T3_CYC + 40000) @(posedge SYS_CLK);
        num_errors++;
        summarize();
    end

    initial begin
        repeat (20) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        rd(A_LOCAL, {24'h0, RST_LOC_WIN}, 32'hffffffff);
        rd(A_STATUS, 32'h004, 32'h3ff);
        rd(A_SEQ, 32'h0, 32'h1ff);
        rd(8'h20, 32'h0, 32'hffffffff);
        i_peer.send(8'h80, 2'h0, 8'h00, 8'h00);
        i_peer.send(8'hc3, 2'h0, 8'h00, 8'h00);
        drain(10);
        rd(A_STATUS, 32'h004, 32'h3ff);
        // Own start, retried after the connection time with a slow peer
        slow <= 1'b1;
        exp_tx.push_back({RS, 8'h04, 8'h00});
        exp_tx.push_back({RS, 8'h04, 8'h00});
        ahb(1'b1, A_CTRL, 32'h1);
        drain(T3_CYC + 2000);
        rd(A_STATUS, 32'h024, 32'h7f);
        i_peer.send(UA, 2'h0, 8'h00, 8'h00);
        rd(A_STATUS, 32'h044, 32'h7f);
        for (int i = 0; i < 10; i++) begin
            @(posedge SYS_CLK);
            I_SENT <= 1'b1;
            I_RCVD_OK <= (i < 2);
            ACK_SENT <= (i == 2);
            @(posedge SYS_CLK);
            {I_SENT, I_RCVD_OK, ACK_SENT} <= 3'h0;
        end
        ACK_NR <= 3'h2;
        i_peer.send(8'hc2, 2'h0, 8'h00, 8'h00);
        rd(A_SEQ, 32'h092, 32'h1ff);
        i_peer.send(8'hd2, 2'h0, 8'h00, 8'h00);
        rd(A_STATUS, 32'h800, 32'hc00);
        exp_tx.push_back({UA, 8'h04, 8'h00});
        i_peer.send(RS, 2'h1, 8'h02, 8'h00);
        drain(20);
        rd(A_SEQ, 32'h0, 32'h1ff);
        rd(A_STATUS, 32'h042, 32'h7f);
        ahb(1'b1, A_LOCAL, 32'h003);
        exp_tx.push_back({RS, 8'h03, 8'h00});
        i_peer.send(RS, 2'h0, 8'h00, 8'h00);
        drain(20);
        exp_tx.push_back({UA, 8'h04, 8'h00});
        i_peer.send(RS, 2'h1, 8'h03, 8'h00);
        drain(20);
        rd(A_STATUS, 32'h043, 32'h7f);
        ahb(1'b1, A_LOCAL, 32'h004);
        exp_tx.push_back({RS, 8'h04, 8'h00});
        i_peer.send(RS, 2'h2, 8'h04, 8'h01);
        drain(20);
        exp_tx.push_back({UA, 8'h04, 8'h00});
        i_peer.send(RS, 2'h2, 8'h04, 8'h00);
        drain(20);
        ahb(1'b1, A_LOCAL, 32'h104);
        exp_tx.push_back({UA, 8'h04, 8'h00});
        i_peer.send(RS, 2'h2, 8'h04, 8'h01);
        drain(20);
        rd(A_STATUS, 32'h244, 32'h27f);
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            ahb(1'b1, A_WINTEST, {23'h0, rnd[8:0]});
            rd(A_WINTEST, {22'h0, inwin(rnd[2:0], rnd[5:3], rnd[8:6]),
               9'h0}, 32'h200);
        end
        drain(10);
        summarize();
    end
endmodule

// [inc/shl_pkg.sv]
package shl_pkg;
    // Control octet layout
    localparam logic [2:0] CTL_U_PFX      = 3'h7;
    localparam logic [1:0] CTL_I_PFX      = 2'h2;
    localparam logic [2:0] CTL_S_PFX      = 3'h6;
    localparam int         MOD_W          = 5;
    localparam logic [4:0] MOD_RESET      = 5'h19;
    localparam logic [4:0] MOD_UACK       = 5'h06;
    localparam logic [1:0] STYPE_RR       = 2'h0;
    localparam logic [1:0] STYPE_REJ      = 2'h1;
    localparam logic [1:0] STYPE_RNR      = 2'h2;
    localparam logic [1:0] STYPE_SREJ     = 2'h3;
    // Window and capability
    localparam logic [7:0] WIN_DEF        = 8'h04;
    localparam logic [7:0] WIN_MIN        = 8'h02;
    localparam int         CAP_SREJ_BIT   = 0;
    localparam logic [7:0] CAP_DEF        = 8'h00;
    // Timing
    localparam int         CLK_HZ         = 10000000;
    localparam int         T1_US_PER_W    = 1250;
    localparam int         T2_US          = 10000;
    localparam int         T3_US          = 5000;
    localparam int         US_CYC         = CLK_HZ / 1000000;
    localparam int         T1_CYC_PER_W   = T1_US_PER_W * US_CYC;
    localparam int         T2_CYC         = T2_US * US_CYC;
    localparam int         T3_CYC         = T3_US * US_CYC;
    localparam int         TMR_W          = 17;
    // Register map
    localparam logic [7:0] A_CTRL         = 8'h00;
    localparam logic [7:0] A_LOCAL        = 8'h04;
    localparam logic [7:0] A_STATUS       = 8'h08;
    localparam logic [7:0] A_SEQ          = 8'h0c;
    localparam logic [7:0] A_WINTEST      = 8'h10;
    localparam logic [7:0] RST_LOC_WIN    = 8'h04;
    localparam logic [7:0] RST_LOC_CAP    = 8'h00;
    typedef enum logic [1:0] {LS_DOWN, LS_WAIT, LS_UP} shl_link_t;
endpackage

// [rtl/shl_link.sv]
`timescale 1ns/1ns
// Overview of operation
// - U-frame modifier is five bits wide
// - Reset 11001 clears sequences; ack is 00110
// - Negotiated window valid until next session
// - Too-large offered window: answer smaller reset
// - Smaller requested window: adopt, answer ack
// - Unsupported capabilities: answer reset, supported only
// - Reset window byte between 2 and 4; code sends loc_win as written, unchecked
// - Answer reset window not above peer's
// - Identical reset answer replaced by ack
// - Capability bit0 selective reject; default zero
// - Ack frame carries no payload
// - Default window four, fixed until reset
// - Acknowledge I-frames within T1 scaled by window
// - Retransmit after guarding time T2
// - Retry setup when T3 expires unanswered
// - Send sequence modulo 8, increments after emission
// - Receive and lowest-unacked sequence tracking
// - Modulo-8 in-window comparison
// - Sequences zero after link established
// - Start/reset sends reset, flushes, notifies
// - Link established on ack receipt
// - Drop frames other than reset and ack before link up
// - Selective reject only after negotiation
// - Supervisory type codes 00 01 10 11
module shl_link (
    // System
    input  wire logic        SYS_CLK,
    input  wire logic        RSTN,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // Received frame, one pulse per frame
    input  wire logic        RX_VALID,
    input  wire logic [7:0]  RX_CTRL,
    input  wire logic [1:0]  RX_PLEN,
    input  wire logic [7:0]  RX_PAY0,
    input  wire logic [7:0]  RX_PAY1,
    input  wire logic        RX_SOF,
    // Frame to send
    output logic             TX_VALID,
    input  wire logic        TX_READY,
    output logic      [7:0]  TX_CTRL,
    output logic      [1:0]  TX_PLEN,
    output logic      [7:0]  TX_PAY0,
    output logic      [7:0]  TX_PAY1,
    // Data-path events
    input  wire logic        I_SENT,
    input  wire logic        I_RCVD_OK,
    input  wire logic [2:0]  ACK_NR,
    input  wire logic        ACK_SENT,
    // Link status and timers
    output logic             LINK_UP,
    output logic             LINK_RESET,
    output logic             FLUSH,
    output logic      [7:0]  WIN,
    output logic             SREJ_EN,
    output logic      [2:0]  NS,
    output logic      [2:0]  NR,
    output logic      [2:0]  DNR,
    output logic             ACK_DUE,
    output logic             RETX_DUE
);
    import shl_pkg::*;

    shl_link_t           state;
    logic      [7:0]     loc_win;
    logic      [7:0]     loc_cap;
    logic                start_req;
    logic      [2:0]     wt_x;
    logic      [2:0]     wt_y;
    logic      [2:0]     wt_z;
    logic                ap_wr;
    logic      [7:0]     ap_addr;
    logic      [TMR_W-1:0] t1_cnt;
    logic      [TMR_W-1:0] t2_cnt;
    logic      [TMR_W-1:0] t3_cnt;
    logic                t1_run;
    logic                t2_run;
    logic                t3_run;
    logic      [7:0]     last_win;
    logic      [7:0]     last_cap;
    logic      [TMR_W-1:0] t1_lim;
    logic      [1:0]     last_stype;

    // Decode of received frame
    logic                rx_is_u;
    logic      [4:0]     rx_mod;
    logic                rx_rset;
    logic                rx_ua;
    logic      [7:0]     off_win;
    logic      [7:0]     off_cap;
    logic                win_ok;
    logic                cap_ok;
    logic      [7:0]     ans_win;
    logic      [7:0]     ans_cap;
    logic                send_ans_rset;
    logic                in_win;

    assign rx_is_u = RX_CTRL[7:5] == CTL_U_PFX;
    assign rx_mod  = RX_CTRL[MOD_W-1:0];
    assign rx_rset = RX_VALID && rx_is_u && rx_mod == MOD_RESET;
    assign rx_ua   = RX_VALID && rx_is_u && rx_mod == MOD_UACK;

    always_comb begin
        off_win = WIN_DEF;
        off_cap = CAP_DEF;
        if (RX_PLEN >= 2'h1) begin
            off_win = RX_PAY0;
        end
        if (RX_PLEN >= 2'h2) begin
            off_cap = RX_PAY1;
        end
    end

    // Peer window out of range treated as too large
    assign win_ok  = off_win <= loc_win && off_win >= WIN_MIN;
    assign cap_ok  = (off_cap & ~loc_cap) == 8'h00;
    always_comb begin
        ans_win = win_ok ? off_win : loc_win;
        if (ans_win > off_win && off_win >= WIN_MIN) begin
            ans_win = off_win;
        end
        ans_cap = off_cap & loc_cap;
    end
    // Identical answer collapses to ack
    assign send_ans_rset = !(win_ok && cap_ok)
                           && !(ans_win == off_win && ans_cap == off_cap);

    // X <= Y < Z modulo 8
    always_comb begin
        if (wt_x <= wt_z) begin
            in_win = (wt_x <= wt_y) && (wt_y < wt_z);
        end else begin
            in_win = (wt_y >= wt_x) || (wt_y < wt_z);
        end
    end

    // AHB-Lite slave, zero wait states
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            ap_wr   <= 1'b0;
            ap_addr <= 8'h00;
        end else if (HREADY) begin
            ap_wr   <= HSEL && HTRANS[1] && HWRITE;
            ap_addr <= HADDR[7:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            HRDATA <= 32'h0;
        end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
            case (HADDR[7:0])
                A_LOCAL:   HRDATA <= {16'h0, loc_cap, loc_win};
                A_STATUS:  HRDATA <= {16'h0, 4'h0, last_stype, SREJ_EN,
                                      RETX_DUE,
                                      ACK_DUE, state == LS_UP, 
                                      state == LS_WAIT, WIN[4:0]};
                A_SEQ:     HRDATA <= {23'h0, DNR, NR, NS};
                A_WINTEST: HRDATA <= {22'h0, in_win, wt_z, wt_y, wt_x};
                default:   HRDATA <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            loc_win   <= RST_LOC_WIN;
            loc_cap   <= RST_LOC_CAP;
            start_req <= 1'b0;
            wt_x      <= 3'h0;
            wt_y      <= 3'h0;
            wt_z      <= 3'h0;
        end else begin
            start_req <= 1'b0;
            if (ap_wr && ap_addr == A_CTRL) begin
                start_req <= HWDATA[0];
            end
            if (ap_wr && ap_addr == A_LOCAL) begin
                loc_win <= HWDATA[7:0];
                loc_cap <= {7'h0, HWDATA[8 + CAP_SREJ_BIT]};
            end
            if (ap_wr && ap_addr == A_WINTEST) begin
                wt_x <= HWDATA[2:0];
                wt_y <= HWDATA[5:3];
                wt_z <= HWDATA[8:6];
            end
        end
    end

    // Link state, negotiation and frame issue
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            state      <= LS_DOWN;
            WIN        <= WIN_DEF;
            SREJ_EN    <= 1'b0;
            last_win   <= WIN_DEF;
            last_cap   <= CAP_DEF;
            TX_VALID   <= 1'b0;
            TX_CTRL    <= 8'h00;
            TX_PLEN    <= 2'h0;
            TX_PAY0    <= 8'h00;
            TX_PAY1    <= 8'h00;
            LINK_RESET <= 1'b0;
            FLUSH      <= 1'b0;
            t3_run     <= 1'b0;
        end else begin
            LINK_RESET <= 1'b0;
            FLUSH      <= 1'b0;
            if (TX_VALID && TX_READY) begin
                TX_VALID <= 1'b0;
            end
            if (RX_SOF) begin
                t3_run <= 1'b0;
            end
            if (start_req || (t3_run && t3_cnt == '0)) begin
                // Offer local window and capabilities
                state      <= LS_WAIT;
                TX_VALID   <= 1'b1;
                TX_CTRL    <= {CTL_U_PFX, MOD_RESET};
                TX_PLEN    <= 2'h2;
                TX_PAY0    <= loc_win;
                TX_PAY1    <= loc_cap;
                last_win   <= loc_win;
                last_cap   <= loc_cap;
                t3_run     <= 1'b1;
                FLUSH      <= 1'b1;
                LINK_RESET <= 1'b1;
            end else if (rx_rset) begin
                FLUSH      <= 1'b1;
                LINK_RESET <= 1'b1;
                TX_VALID   <= 1'b1;
                if (send_ans_rset) begin
                    state    <= LS_WAIT;
                    TX_CTRL  <= {CTL_U_PFX, MOD_RESET};
                    TX_PLEN  <= 2'h2;
                    TX_PAY0  <= ans_win;
                    TX_PAY1  <= ans_cap;
                    last_win <= ans_win;
                    last_cap <= ans_cap;
                    t3_run   <= 1'b1;
                end else begin
                    // Responder counts link up as soon as its ack is queued, before TX_READY takes it
                    state    <= LS_UP;
                    TX_CTRL  <= {CTL_U_PFX, MOD_UACK};
                    TX_PLEN  <= 2'h0;
                    WIN      <= ans_win;
                    SREJ_EN  <= ans_cap[CAP_SREJ_BIT];
                    t3_run   <= 1'b0;
                end
            end else if (rx_ua && state == LS_WAIT) begin
                state   <= LS_UP;
                WIN     <= last_win;
                SREJ_EN <= last_cap[CAP_SREJ_BIT];
                t3_run  <= 1'b0;
            end
        end
    end

    assign LINK_UP = state == LS_UP;

    // Sequence variables
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            NS  <= 3'h0;
            NR  <= 3'h0;
            DNR <= 3'h0;
        end else if (state != LS_UP || LINK_RESET) begin
            NS  <= 3'h0;
            NR  <= 3'h0;
            DNR <= 3'h0;
        end else if (!RX_VALID || !rx_is_u) begin
            // Non-U frames reach here only with link up
            if (I_SENT) begin
                NS <= NS + 3'h1;
            end
            if (I_RCVD_OK) begin
                NR <= NR + 3'h1;
            end
            if (RX_VALID) begin
                DNR <= ACK_NR;
            end
        end
    end

    // Timers: T1 ack, T2 guard, T3 connect
    assign t1_lim = TMR_W'(T1_CYC_PER_W) * TMR_W'(WIN);

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            t1_run  <= 1'b0;
            t1_cnt  <= '0;
            ACK_DUE <= 1'b0;
        end else begin
            ACK_DUE <= 1'b0;
            if (!LINK_UP) begin
                t1_run <= 1'b0;
            end else if (I_RCVD_OK && (!t1_run || ACK_SENT)) begin
                t1_run <= 1'b1;
                t1_cnt <= t1_lim - TMR_W'(1);
            end else if (ACK_SENT) begin
                t1_run <= 1'b0;
            end else if (t1_run) begin
                if (t1_cnt == '0) begin
                    ACK_DUE <= 1'b1;
                    t1_run  <= 1'b0;
                end else begin
                    t1_cnt <= t1_cnt - TMR_W'(1);
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            t2_run   <= 1'b0;
            t2_cnt   <= '0;
            RETX_DUE <= 1'b0;
        end else begin
            RETX_DUE <= 1'b0;
            if (!LINK_UP) begin
                t2_run <= 1'b0;
            end else if (I_SENT && (!t2_run || DNR == NS)) begin
                t2_run <= 1'b1;
                t2_cnt <= TMR_W'(T2_CYC);
            end else if (DNR == NS) begin
                t2_run <= 1'b0;
            end else if (t2_run) begin
                if (t2_cnt == '0) begin
                    RETX_DUE <= 1'b1;
                    t2_cnt   <= TMR_W'(T2_CYC);
                end else begin
                    t2_cnt <= t2_cnt - TMR_W'(1);
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            t3_cnt <= '0;
        end else if (!t3_run || TX_VALID) begin
            t3_cnt <= TMR_W'(T3_CYC - 1);
        end else if (t3_cnt != '0) begin
            t3_cnt <= t3_cnt - TMR_W'(1);
        end
    end

    // Type of the last supervisory frame taken with link up
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            last_stype <= STYPE_RR;
        end else if (LINK_UP && RX_VALID && RX_CTRL[7:5] == CTL_S_PFX) begin
            last_stype <= RX_CTRL[4:3];
        end
    end
endmodule
